/* File: logic/stamp_capture_regs.svh */
// register offsets, field positions and reset values of the capture block
`ifndef STAMP_CAPTURE_REGS_SVH
`define STAMP_CAPTURE_REGS_SVH

// ==========================================================
// register offsets (register numbers on the register port)
`define CMD_ADDR          16'h0064
`define STATUS_ADDR       16'h006e
`define USER_LEN_ADDR     16'h00dc
`define USER_POS_ADDR     16'h00dd
`define CARD_LEN_ADDR     16'h00de
`define BUF_LEN_ADDR      16'h00e0
`define TS_CMD_ADDR       16'hb7fc

// ==========================================================
// field positions
`define CMD_POLL_BIT      23
`define CMD_DMA_START_BIT 20
`define STAT_ERROR_BIT    15
`define STAT_OVERRUN_BIT  14
`define STAT_POLL_BIT     0
`define TS_XIO_BIT        12
`define WORD_BYTES_SHIFT  3

// ==========================================================
// reset values
`define TS_CMD_RESET      32'h0000_0000
`define BUF_LEN_RESET     32'h0000_0000

`endif

/* File: logic/stamp_pkg.sv */
// types shared by the timestamp capture block
package stamp_pkg;

  // counting mode, set outside this block
  typedef enum logic [1:0] {
    mode_standard    = 2'b00,
    mode_start_reset = 2'b01,
    mode_refclock    = 2'b11
  } count_mode_type;

  typedef enum logic {
    drain_idle = 1'b0,
    drain_busy = 1'b1
  } drain_state_type;

  // one fifo entry: top byte and 56-bit stamp
  typedef struct packed {
    logic [7:0]  top;
    logic [55:0] stamp;
  } stamp_word_type;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [31:0] data;
  } reg_write_type;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
  } reg_read_type;

endpackage : stamp_pkg

/* File: logic/bit_sync2.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bit_sync2 #(
  parameter int width = 1
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // data
  input  wire logic [width-1:0] d,
  output logic      [width-1:0] q
);

  logic [width-1:0] meta_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : bit_sync2

/* File: logic/aux_fifo.sv */
// auxiliary fifo holding whole stamp words in trigger order
`timescale 1ns/1ps
module aux_fifo #(
  parameter int width = 64,
  parameter int depth = 64,
  localparam int aw = $clog2(depth)
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             wr_valid,
  input  wire logic [width-1:0] wr_data,
  output logic                  wr_ready,
  // drain side
  output logic                  rd_valid,
  output logic      [width-1:0] rd_data,
  input  wire logic             rd_ready,
  // fill level
  output logic      [aw:0]      count
);

  if (depth < 2 || (depth & (depth - 1)) != 0) begin : g_chk
    $error("depth must be a power of two, at least 2");
  end

  logic [width-1:0] mem [depth];
  logic [aw:0]      wp_reg;
  logic [aw:0]      wp_next;
  logic [aw:0]      rp_reg;
  logic [aw:0]      rp_next;

  always_comb begin
    wr_ready = !((wp_reg[aw] != rp_reg[aw]) &&
                 (wp_reg[aw-1:0] == rp_reg[aw-1:0]));
    rd_valid = (wp_reg != rp_reg);
    rd_data  = mem[rp_reg[aw-1:0]];
    count    = wp_reg - rp_reg;
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    if (wr_valid && wr_ready) begin
      wp_next = wp_reg + 1'b1;
    end
    if (rd_ready && rd_valid) begin
      rp_next = rp_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  // storage needs no reset; only written entries are read
  always_ff @(posedge ref_clk) begin
    if (wr_valid && wr_ready) begin
      mem[wp_reg[aw-1:0]] <= wr_data;
    end
  end

endmodule : aux_fifo

/* File: logic/trigger_timestamp_capture_poll.sv */
// trigger timestamp capture with polled auxiliary fifo readout
//
// Summary of operation
// - stamp is 56 bits, sent as 64-bit word
// - counter counts sample ticks since last reset
// - fixed latency from trigger to capture
// - standard modes: bits 55..0 hold stamp
// - refclock mode: 32 sample, 24 seconds bits
// - capture off: top byte is zero
// - capture flag set: top byte holds inputs
// - flag written zero selects zero fill
// - command register is a bitfield, all modes
// - polling starts on the poll command
// - length read drains fifo, returns bytes moved
// - overrun stops transfer, sets overrun bit
// - dma and polling never mixed
`timescale 1ns/1ps
`include "stamp_capture_regs.svh"
module trigger_timestamp_capture_poll #(
  parameter int fifo_depth = 64
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // acquisition side
  input  wire logic                     sample_tick,
  input  wire logic                     counter_clear,
  input  wire logic                     trigger,
  input  wire stamp_pkg::count_mode_type count_mode,
  // pins
  input  wire logic                     refclk_pin,
  input  wire logic [7:0]               ext_input_pins,
  // register port
  input  wire stamp_pkg::reg_write_type reg_wr,
  input  wire stamp_pkg::reg_read_type  reg_rd,
  output logic [31:0]                   rd_data,
  output logic                          rd_valid,
  // drain stream into the host buffer
  output logic                          drain_valid,
  output stamp_pkg::stamp_word_type     drain_word,
  output logic [31:0]                   drain_addr,
  // status
  output logic                          poll_active,
  output logic                          aux_overrun_flag
);
  import stamp_pkg::*;

  localparam int cw = $clog2(fifo_depth) + 1;

  if (fifo_depth < 2 || (fifo_depth & (fifo_depth - 1)) != 0) begin : g_chk
    $error("fifo_depth must be a power of two, at least 2");
  end

  // ==========================================================
  // pin synchronisers
  logic       ref_s;
  logic [7:0] ext_s;

  bit_sync2 #(.width(1)) u_ref_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       (refclk_pin),
    .q       (ref_s)
  );

  bit_sync2 #(.width(8)) u_ext_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       (ext_input_pins),
    .q       (ext_s)
  );

  // ==========================================================
  // counter and capture
  logic [55:0]    cnt_reg;
  logic [55:0]    cnt_next;
  logic           ref_d_reg;
  logic           ref_rise;
  logic           cap_valid_reg;
  logic           cap_valid_next;
  stamp_word_type cap_word_reg;
  stamp_word_type cap_word_next;
  logic [31:0]    ts_cmd_reg;

  always_comb begin
    ref_rise = ref_s && !ref_d_reg;
    cnt_next = cnt_reg;
    if (counter_clear) begin
      cnt_next = '0;
    end else if (count_mode == mode_refclock) begin
      if (ref_rise) begin
        cnt_next[55:32] = cnt_reg[55:32] + 24'h1;
        cnt_next[31:0]  = '0;
      end else if (sample_tick) begin
        cnt_next[31:0] = cnt_reg[31:0] + 32'h1;
      end
    end else if (sample_tick) begin
      cnt_next = cnt_reg + 56'h1;
    end
    // word taken in the trigger cycle, fifo write one edge later
    cap_valid_next      = trigger && !aux_overrun_flag;
    cap_word_next.stamp = cnt_reg;
    cap_word_next.top   = 8'h00;
    if (ts_cmd_reg[`TS_XIO_BIT]) begin
      cap_word_next.top = ext_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg       <= '0;
      ref_d_reg     <= 1'b0;
      cap_valid_reg <= 1'b0;
      cap_word_reg  <= '0;
    end else begin
      cnt_reg       <= cnt_next;
      ref_d_reg     <= ref_s;
      cap_valid_reg <= cap_valid_next;
      cap_word_reg  <= cap_word_next;
    end
  end

  // ==========================================================
  // auxiliary fifo
  logic            fifo_wr_ready;
  logic            fifo_rd_valid;
  logic            fifo_rd_ready;
  logic [63:0]     fifo_rd_data;
  logic [cw-1:0]   fifo_count;
  drain_state_type drain_state_reg;

  assign fifo_rd_ready = (drain_state_reg == drain_busy);

  aux_fifo #(.width(64), .depth(fifo_depth)) u_fifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .wr_valid (cap_valid_reg),
    .wr_data  (cap_word_reg),
    .wr_ready (fifo_wr_ready),
    .rd_valid (fifo_rd_valid),
    .rd_data  (fifo_rd_data),
    .rd_ready (fifo_rd_ready),
    .count    (fifo_count)
  );

  // ==========================================================
  // registers and polled drain
  drain_state_type drain_state_next;
  logic [31:0]     ts_cmd_next;
  logic [31:0]     buf_len_reg;
  logic [31:0]     buf_len_next;
  logic [31:0]     card_free_reg;
  logic [31:0]     card_free_next;
  logic [31:0]     user_len_reg;
  logic [31:0]     user_len_next;
  logic [31:0]     user_pos_reg;
  logic [31:0]     user_pos_next;
  logic [31:0]     wr_pos_reg;
  logic [31:0]     wr_pos_next;
  logic [31:0]     drain_left_reg;
  logic [31:0]     drain_left_next;
  logic            misuse_reg;
  logic            misuse_next;
  logic            poll_next;
  logic            overrun_next;
  logic [31:0]     rd_data_next;
  logic            rd_valid_next;
  logic            drain_valid_next;
  stamp_word_type  drain_word_next;
  logic [31:0]     drain_addr_next;
  logic [31:0]     take_words;
  logic [31:0]     free_words;
  logic [31:0]     take_bytes;
  logic [31:0]     pos_step;
  logic            cmd_wr;

  always_comb begin
    ts_cmd_next      = ts_cmd_reg;
    buf_len_next     = buf_len_reg;
    card_free_next   = card_free_reg;
    user_len_next    = user_len_reg;
    user_pos_next    = user_pos_reg;
    wr_pos_next      = wr_pos_reg;
    drain_left_next  = drain_left_reg;
    drain_state_next = drain_state_reg;
    misuse_next      = misuse_reg;
    poll_next        = poll_active;
    overrun_next     = aux_overrun_flag;
    rd_data_next     = 32'h0000_0000;
    rd_valid_next    = reg_rd.en;
    drain_valid_next = 1'b0;
    drain_word_next  = drain_word;
    drain_addr_next  = drain_addr;
    cmd_wr           = reg_wr.en && (reg_wr.addr == `CMD_ADDR);
    free_words       = card_free_reg >> `WORD_BYTES_SHIFT;
    take_words       = 32'(fifo_count);
    if (free_words < take_words) begin
      take_words = free_words;
    end
    take_bytes = take_words << `WORD_BYTES_SHIFT;
    pos_step   = wr_pos_reg + 32'h8;
    if (pos_step >= buf_len_reg) begin
      pos_step = 32'h0000_0000;
    end

    // one whole word per cycle leaves the fifo in order
    unique case (drain_state_reg)
      drain_idle: begin
      end
      drain_busy: begin
        drain_valid_next = fifo_rd_valid;
        drain_word_next  = fifo_rd_data;
        drain_addr_next  = wr_pos_reg;
        wr_pos_next      = pos_step;
        drain_left_next  = drain_left_reg - 32'h1;
        if (drain_left_reg == 32'h1) begin
          drain_state_next = drain_idle;
        end
      end
    endcase

    // register reads
    if (reg_rd.en) begin
      unique case (reg_rd.addr)
        `STATUS_ADDR: begin
          rd_data_next[`STAT_ERROR_BIT]   = misuse_reg;
          rd_data_next[`STAT_OVERRUN_BIT] = aux_overrun_flag;
          rd_data_next[`STAT_POLL_BIT]    = poll_active;
        end
        `USER_LEN_ADDR: begin
          if (poll_active && drain_state_reg == drain_idle &&
              take_words != 32'h0) begin
            rd_data_next     = take_bytes;
            user_len_next    = take_bytes;
            user_pos_next    = wr_pos_reg;
            card_free_next   = card_free_reg - take_bytes;
            drain_left_next  = take_words;
            drain_state_next = drain_busy;
          end
        end
        `USER_POS_ADDR: rd_data_next = user_pos_reg;
        `BUF_LEN_ADDR:  rd_data_next = buf_len_reg;
        `TS_CMD_ADDR:   rd_data_next = ts_cmd_reg;
        default:        rd_data_next = 32'h0000_0000;
      endcase
    end

    // register writes
    if (reg_wr.en && reg_wr.addr == `TS_CMD_ADDR) begin
      ts_cmd_next = reg_wr.data;
    end
    if (reg_wr.en && reg_wr.addr == `BUF_LEN_ADDR) begin
      buf_len_next = reg_wr.data;
    end
    if (reg_wr.en && reg_wr.addr == `CARD_LEN_ADDR) begin
      card_free_next = card_free_next + reg_wr.data;
    end
    if (cmd_wr && reg_wr.data[`CMD_DMA_START_BIT] &&
        (poll_active || reg_wr.data[`CMD_POLL_BIT])) begin
      misuse_next = 1'b1;
    end else if (cmd_wr && reg_wr.data[`CMD_POLL_BIT]) begin
      poll_next        = 1'b1;
      overrun_next     = 1'b0;
      misuse_next      = 1'b0;
      card_free_next   = buf_len_reg;
      user_len_next    = 32'h0000_0000;
      user_pos_next    = 32'h0000_0000;
      wr_pos_next      = 32'h0000_0000;
      drain_state_next = drain_idle;
    end

    // an overrun in the same cycle wins over a restart
    if (cap_valid_reg && !fifo_wr_ready) begin
      overrun_next     = 1'b1;
      poll_next        = 1'b0;
      drain_state_next = drain_idle;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ts_cmd_reg       <= `TS_CMD_RESET;
      buf_len_reg      <= `BUF_LEN_RESET;
      card_free_reg    <= '0;
      user_len_reg     <= '0;
      user_pos_reg     <= '0;
      wr_pos_reg       <= '0;
      drain_left_reg   <= '0;
      drain_state_reg  <= drain_idle;
      misuse_reg       <= 1'b0;
      poll_active      <= 1'b0;
      aux_overrun_flag <= 1'b0;
      rd_data          <= '0;
      rd_valid         <= 1'b0;
      drain_valid      <= 1'b0;
      drain_word       <= '0;
      drain_addr       <= '0;
    end else begin
      ts_cmd_reg       <= ts_cmd_next;
      buf_len_reg      <= buf_len_next;
      card_free_reg    <= card_free_next;
      user_len_reg     <= user_len_next;
      user_pos_reg     <= user_pos_next;
      wr_pos_reg       <= wr_pos_next;
      drain_left_reg   <= drain_left_next;
      drain_state_reg  <= drain_state_next;
      misuse_reg       <= misuse_next;
      poll_active      <= poll_next;
      aux_overrun_flag <= overrun_next;
      rd_data          <= rd_data_next;
      rd_valid         <= rd_valid_next;
      drain_valid      <= drain_valid_next;
      drain_word       <= drain_word_next;
      drain_addr       <= drain_addr_next;
    end
  end

endmodule : trigger_timestamp_capture_poll

/* File: sim/trigger_timestamp_capture_poll_properties.sv */
// checker for the timestamp capture block, bound to its ports
`timescale 1ns/1ps
`include "stamp_capture_regs.svh"
module trigger_timestamp_capture_poll_properties (
  // clock and reset
  input wire logic                     ref_clk,
  input wire logic                     rst,
  // register port
  input wire stamp_pkg::reg_write_type reg_wr,
  input wire stamp_pkg::reg_read_type  reg_rd,
  input wire logic [31:0]              rd_data,
  input wire logic                     rd_valid,
  // drain and status
  input wire logic                     drain_valid,
  input wire logic [31:0]              drain_addr,
  input wire logic                     poll_active,
  input wire logic                     aux_overrun_flag
);
  import stamp_pkg::*;
  logic poll_cmd;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  assign poll_cmd = reg_wr.en && reg_wr.addr == `CMD_ADDR
                    && reg_wr.data[`CMD_POLL_BIT]
                    && !reg_wr.data[`CMD_DMA_START_BIT];

  // ==========================================================
  // properties
  a_read_answer: assert property (reg_rd.en |=> rd_valid)
    else $error("read not answered next cycle");
  a_answer_only: assert property (!reg_rd.en |=> !rd_valid)
    else $error("answer without a read");
  a_poll_starts: assert property (
    poll_cmd |-> ##[1:2] (poll_active || aux_overrun_flag))
    else $error("poll command did not start polling");
  a_overrun_stops: assert property (
    aux_overrun_flag |-> !poll_active)
    else $error("polling still running after overrun");
  a_overrun_sticky: assert property (
    aux_overrun_flag && !poll_cmd |=> aux_overrun_flag)
    else $error("overrun flag dropped without poll command");
  a_drain_follows: assert property (
    $rose(drain_valid) |-> $past(rd_valid)
      && $past(reg_rd.addr, 2) == `USER_LEN_ADDR)
    else $error("drain began without a length read");
  a_drain_step: assert property (
    drain_valid && $past(drain_valid)
      |-> drain_addr == $past(drain_addr) + 32'h8 || drain_addr == 32'h0)
    else $error("drained words not at consecutive positions");
  a_len_bytes: assert property (
    rd_valid && rd_data != 32'h0 && $past(reg_rd.addr) == `USER_LEN_ADDR
      |-> rd_data[2:0] == 3'h0 ##1 (drain_valid || aux_overrun_flag))
    else $error("length answer not whole words");
endmodule : trigger_timestamp_capture_poll_properties

bind trigger_timestamp_capture_poll
  trigger_timestamp_capture_poll_properties i_props (
  .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .rd_data(rd_data), .rd_valid(rd_valid), .drain_valid(drain_valid),
  .drain_addr(drain_addr), .poll_active(poll_active),
  .aux_overrun_flag(aux_overrun_flag)
);

/* File: sim/stamp_host_model.sv */
// host buffer model that keeps the latest drained stamp word at each of its eight positions
`timescale 1ns/1ps
module stamp_host_model (
  // clock
  input wire logic                      ref_clk,
  // drain stream
  input wire logic                      drain_valid,
  input wire stamp_pkg::stamp_word_type drain_word,
  input wire logic [31:0]               drain_addr
);
  import stamp_pkg::*;
  logic [63:0] mem [0:7];

  // 64-byte buffer, word placed at its byte position
  always_ff @(posedge ref_clk) begin
    if (drain_valid) begin
      mem[drain_addr[5:3]] <= drain_word;
    end
  end

  // top byte masked off before arithmetic
  function automatic logic [63:0] plain(input logic [63:0] w);
    return {8'h00, w[55:0]};
  endfunction : plain
endmodule : stamp_host_model

/* File: sim/trigger_timestamp_capture_poll_bench.sv */
// self-checking bench for the timestamp capture block
`timescale 1ns/1ps
`include "stamp_capture_regs.svh"
module trigger_timestamp_capture_poll_bench;
  import stamp_pkg::*;
  logic           ref_clk = 1'b0;
  logic           rst = 1'b1;
  logic           sample_tick = 1'b0;
  logic           counter_clear = 1'b0;
  logic           trigger = 1'b0;
  count_mode_type count_mode = mode_standard;
  logic           refclk_pin = 1'b0;
  logic [7:0]     ext_input_pins = 8'h00;
  reg_write_type  reg_wr = '0;
  reg_read_type   reg_rd = '0;
  logic [31:0]    rd_data;
  logic           rd_valid;
  logic           drain_valid;
  stamp_word_type drain_word;
  logic [31:0]    drain_addr;
  logic           poll_active;
  logic           aux_overrun_flag;
  logic [63:0]    exp_q [$];
  int             err_count = 0;
  int             num_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  trigger_timestamp_capture_poll #(.fifo_depth(4)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .sample_tick(sample_tick),
    .counter_clear(counter_clear), .trigger(trigger),
    .count_mode(count_mode), .refclk_pin(refclk_pin),
    .ext_input_pins(ext_input_pins), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .rd_data(rd_data), .rd_valid(rd_valid), .drain_valid(drain_valid),
    .drain_word(drain_word), .drain_addr(drain_addr),
    .poll_active(poll_active), .aux_overrun_flag(aux_overrun_flag)
  );

  stamp_host_model i_host (
    .ref_clk(ref_clk), .drain_valid(drain_valid),
    .drain_word(drain_word), .drain_addr(drain_addr)
  );

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_wr <= '{1'b1, a, d};
    @(negedge ref_clk);
    reg_wr.en <= 1'b0;
    @(negedge ref_clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] m, e);
    reg_rd <= '{1'b1, a};
    @(negedge ref_clk);
    chk(rd_valid, 1'b1);
    chk(rd_data & m, e);
    reg_rd.en <= 1'b0;
    @(negedge ref_clk);
  endtask : rd

  // clear counter, optional reference edge, k ticks, then trigger
  task automatic stamp(input int k, input bit sec);
    counter_clear <= 1'b1;
    @(negedge ref_clk);
    counter_clear <= 1'b0;
    if (sec) begin
      refclk_pin <= 1'b1;
      repeat (3) @(negedge ref_clk);
      refclk_pin <= 1'b0;
      repeat (6) @(negedge ref_clk);
    end
    repeat (k) begin
      sample_tick <= 1'b1;
      @(negedge ref_clk);
    end
    sample_tick <= 1'b0;
    trigger <= 1'b1;
    @(negedge ref_clk);
    trigger <= 1'b0;
    @(negedge ref_clk);
  endtask : stamp

  task automatic drain(input logic [31:0] pos);
    logic [31:0] n;
    n = 32'(exp_q.size() * 8);
    rd(`USER_LEN_ADDR, 32'hffff_ffff, n);
    rd(`USER_POS_ADDR, 32'hffff_ffff, pos);
    repeat (4) @(negedge ref_clk);
    foreach (exp_q[i]) begin
      chk(i_host.mem[(pos[5:3] + i) % 8], exp_q[i]);
    end
    wr(`CARD_LEN_ADDR, n);
    exp_q.delete();
  endtask : drain

  // ==========================================================
  // scenarios
  task automatic t_registers();
    rd(`TS_CMD_ADDR, 32'hffff_ffff, `TS_CMD_RESET);
    wr(`TS_CMD_ADDR, 32'h0000_1000);
    rd(`TS_CMD_ADDR, 32'hffff_ffff, 32'h0000_1000);
    wr(`TS_CMD_ADDR, 32'h0000_0000);
    rd(`TS_CMD_ADDR, 32'hffff_ffff, 32'h0000_0000);
    rd(16'h0123, 32'hffff_ffff, 32'h0000_0000);
    rd(`USER_LEN_ADDR, 32'hffff_ffff, 32'h0000_0000);
    chk(poll_active, 1'b0);
    wr(`BUF_LEN_ADDR, 32'h0000_0040);
    wr(`CMD_ADDR, 32'h0080_0000);
    chk(poll_active, 1'b1);
  endtask : t_registers

  task automatic t_plain();
    stamp(5, 1'b0);
    stamp(0, 1'b0);
    stamp(7, 1'b0);
    exp_q = '{64'h5, 64'h0, 64'h7};
    drain(32'h0);
  endtask : t_plain

  task automatic t_ext_inputs();
    count_mode <= mode_start_reset;
    ext_input_pins <= 8'ha5;
    wr(`TS_CMD_ADDR, 32'h0000_1000);
    stamp(9, 1'b0);
    wr(`TS_CMD_ADDR, 32'h0000_0000);
    stamp(2, 1'b0);
    exp_q = '{64'ha500_0000_0000_0009, 64'h2};
    drain(32'h18);
    chk(i_host.plain(i_host.mem[3]), 64'h9);
  endtask : t_ext_inputs

  task automatic t_refclock();
    count_mode <= mode_refclock;
    ext_input_pins <= 8'h3c;
    wr(`TS_CMD_ADDR, 32'h0000_1000);
    stamp(4, 1'b1);
    exp_q = '{64'h3c00_0001_0000_0004};
    drain(32'h28);
    wr(`TS_CMD_ADDR, 32'h0000_0000);
  endtask : t_refclock

  task automatic t_dma_reject();
    wr(`CMD_ADDR, 32'h0010_0000);
    rd(`STATUS_ADDR, 32'h0000_8001, 32'h0000_8001);
  endtask : t_dma_reject

  task automatic t_overrun();
    repeat (5) stamp(1, 1'b0);
    chk(aux_overrun_flag, 1'b1);
    chk(poll_active, 1'b0);
    rd(`STATUS_ADDR, 32'h0000_4001, 32'h0000_4000);
    rd(`USER_LEN_ADDR, 32'hffff_ffff, 32'h0000_0000);
    wr(`CMD_ADDR, 32'h0080_0000);
    chk(aux_overrun_flag, 1'b0);
    chk(poll_active, 1'b1);
  endtask : t_overrun

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (6) @(negedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    t_registers();
    t_plain();
    t_ext_inputs();
    t_refclock();
    t_dma_reject();
    t_overrun();
    conclude();
  end

  // watchdog: far beyond the roughly 150 cycles the scenarios need
  initial begin
    #50000;
    err_count++;
    conclude();
  end
endmodule : trigger_timestamp_capture_poll_bench
